// ### src/tid_top.sv
// tid_top: four-channel tachometer input conditioning with AXI4-Lite registers
// Operation
// [R1] Four channels, each with its own independent comparator, coupling, polarity, debounce.
// [R2] Per-channel coupling select: DC direct, AC through 1 Hz high-pass.
// [R3] Threshold code spans -12.5 V to +12.5 V in 100 mV steps.
// [R4] Per-channel polarity select may invert comparator output before debounce.
// [R5] Bypass ignores the interval and passes the polarity-selected signal straight on.
// [R6] Sixteen selectable intervals, applied in both debounce modes.
// [R7] Intervals range 500 ns to 25.5 ms, plus a no-delay choice.
// [R8] Settle-then-pass: output changes only after input held the level for interval.
// [R9] Pass-then-hold: edge passes at once if input was stable beforehand.
// [R10] Pass-then-hold: after a change, edges ignored until input stable again.
// [R11] Comparator-side waveform is gain adjusted and muxed into the acquisition scan.
// [R12] Accepted edges clock the channel's counter module.
// [R13] Comparator output double-synchronised; stability timer restarts on each change.
// [R14] Four-bit interval field: one code no delay, others fixed cycle counts.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module tid_top #(
  parameter int NUM_CH = 4,
  parameter logic [16*tid_pkg::CNT_W-1:0] P_IVL_CYCLES = tid_pkg::IVL_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // AXI4-Lite slave
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // comparator outputs of each channel
  input wire logic i_speed_pulse_input_a,
  input wire logic i_speed_pulse_input_b,
  input wire logic i_speed_pulse_input_c,
  input wire logic i_speed_pulse_input_d,
  // analog front-end controls
  output logic [3:0] o_coupling_ac,
  output logic [7:0] o_threshold_a,
  output logic [7:0] o_threshold_b,
  output logic [7:0] o_threshold_c,
  output logic [7:0] o_threshold_d,
  output logic [1:0] o_scan_sel,
  output logic [3:0] o_scan_gain,
  // cleaned pulses to the counter modules
  output logic [3:0] o_counter_clk
);
  localparam int CW = tid_pkg::CNT_W;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // merge write data into a register by byte lanes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        v[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return v;
  endfunction : merge_bytes

  // map a byte address onto a channel index, or flag it as no channel
  function automatic logic [2:0] ctrl_index(input logic [7:0] addr);
    case (addr)
      tid_pkg::CTRL_A_OFS: ctrl_index = 3'h0;
      tid_pkg::CTRL_B_OFS: ctrl_index = 3'h1;
      tid_pkg::CTRL_C_OFS: ctrl_index = 3'h2;
      tid_pkg::CTRL_D_OFS: ctrl_index = 3'h3;
      default: ctrl_index = 3'h4;
    endcase
  endfunction : ctrl_index

  // clamp a threshold code to the usable span
  function automatic logic [7:0] clamp_thr(input logic [7:0] code);
    clamp_thr = (code > tid_pkg::THR_MAX_CODE) ? tid_pkg::THR_MAX_CODE : code;
  endfunction : clamp_thr

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [31:0] ctrl [NUM_CH];
  logic [31:0] scan_reg;
  logic [3:0] sync_in;
  logic [3:0] clean;

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [2:0] wr_idx;

  // address and data are taken independently, in either order
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_s_axi_awready <= 1'b0;
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else begin
      o_s_axi_awready <= 1'b0;
      if (o_s_axi_awready && i_s_axi_awvalid) begin
        aw_held <= 1'b1;
        aw_addr <= i_s_axi_awaddr;
        o_s_axi_awready <= 1'b0;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (!aw_held && !o_s_axi_awready && !o_s_axi_bvalid && i_s_axi_awvalid) begin
        o_s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_s_axi_wready <= 1'b0;
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      o_s_axi_wready <= 1'b0;
      if (o_s_axi_wready && i_s_axi_wvalid) begin
        w_held <= 1'b1;
        w_data <= i_s_axi_wdata;
        w_strb <= i_s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end else if (!w_held && !o_s_axi_bvalid && i_s_axi_wvalid) begin
        o_s_axi_wready <= 1'b1;
      end
    end
  end

  assign do_write = aw_held && w_held && !o_s_axi_bvalid;
  assign wr_addr = aw_addr;
  assign wr_data = w_data;
  assign wr_strb = w_strb;
  assign wr_idx = ctrl_index(wr_addr);

  // write response follows both halves
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= tid_pkg::RESP_OKAY;
    end else if (do_write) begin
      o_s_axi_bvalid <= 1'b1;
      o_s_axi_bresp <= (wr_idx != 3'h4 || wr_addr == tid_pkg::SCAN_OFS) ?
                       tid_pkg::RESP_OKAY : tid_pkg::RESP_SLVERR;
    end else if (i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  // per-channel control registers, independent of each other
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ctrl
      always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
          ctrl[c] <= tid_pkg::CTRL_RST; // R1
        end else if (do_write && wr_idx == 3'(c)) begin
          ctrl[c] <= merge_bytes(ctrl[c], wr_data, wr_strb); // R1
        end
      end
    end
  endgenerate

  // scan multiplexer control
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      scan_reg <= tid_pkg::SCAN_RST;
    end else if (do_write && wr_addr == tid_pkg::SCAN_OFS) begin
      scan_reg <= merge_bytes(scan_reg, wr_data, wr_strb);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  logic [2:0] rd_idx;
  assign rd_idx = ctrl_index(i_s_axi_araddr);

  // one read at a time, answered the cycle after the address is taken
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h00000000;
      o_s_axi_rresp <= tid_pkg::RESP_OKAY;
    end else begin
      o_s_axi_arready <= 1'b0;
      if (o_s_axi_arready && i_s_axi_arvalid) begin
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rresp <= tid_pkg::RESP_OKAY;
        if (rd_idx != 3'h4) begin
          o_s_axi_rdata <= ctrl[rd_idx[1:0]];
        end else if (i_s_axi_araddr == tid_pkg::SCAN_OFS) begin
          o_s_axi_rdata <= scan_reg;
        end else if (i_s_axi_araddr == tid_pkg::STATUS_OFS) begin
          o_s_axi_rdata <= {24'h000000, sync_in, o_counter_clk};
        end else begin
          o_s_axi_rdata <= 32'h00000000;
          o_s_axi_rresp <= tid_pkg::RESP_SLVERR;
        end
      end else if (o_s_axi_rvalid) begin
        if (i_s_axi_rready) begin
          o_s_axi_rvalid <= 1'b0;
        end
      end else if (i_s_axi_arvalid) begin
        o_s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // analog front-end controls
  // ----------------------------------------------------------------

  // coupling, threshold and scan selection driven from registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_coupling_ac <= {NUM_CH{tid_pkg::CTRL_RST[tid_pkg::CPL_BIT]}};
      o_threshold_a <= tid_pkg::THR_RST;
      o_threshold_b <= tid_pkg::THR_RST;
      o_threshold_c <= tid_pkg::THR_RST;
      o_threshold_d <= tid_pkg::THR_RST;
      o_scan_sel <= 2'h0;
      o_scan_gain <= 4'h0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        o_coupling_ac[c] <= ctrl[c][tid_pkg::CPL_BIT]; // R2
      end
      o_threshold_a <= clamp_thr(ctrl[0][tid_pkg::THR_LSB +: 8]); // R3
      o_threshold_b <= clamp_thr(ctrl[1][tid_pkg::THR_LSB +: 8]); // R3
      o_threshold_c <= clamp_thr(ctrl[2][tid_pkg::THR_LSB +: 8]); // R3
      o_threshold_d <= clamp_thr(ctrl[3][tid_pkg::THR_LSB +: 8]); // R3
      o_scan_sel <= scan_reg[tid_pkg::SCAN_SEL_LSB +: 2]; // R11
      o_scan_gain <= scan_reg[tid_pkg::SCAN_GAIN_LSB +: 4]; // R11
    end
  end

  // ----------------------------------------------------------------
  // pulse path: synchronise, invert, debounce
  // ----------------------------------------------------------------
  tid_sync #(
    .WIDTH(4)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_speed_pulse_input_d, i_speed_pulse_input_c,
              i_speed_pulse_input_b, i_speed_pulse_input_a}),
    .o_sync(sync_in) // R13
  );

  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      logic pol_level;
      logic [3:0] ivl_code;
      logic [CW-1:0] limit;
      assign pol_level = sync_in[c] ^ ctrl[c][tid_pkg::INV_BIT]; // R4
      assign ivl_code = ctrl[c][tid_pkg::IVL_LSB +: 4];
      assign limit = P_IVL_CYCLES[ivl_code*CW +: CW]; // R6 R7 R14

      tid_debounce #(
        .CNT_W(CW)
      ) u_deb (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_level(pol_level),
        .i_mode(ctrl[c][tid_pkg::MODE_LSB +: 2]),
        .i_limit(limit),
        .o_level(clean[c])
      );
    end
  endgenerate

  // accepted edges clock the counter modules
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_counter_clk <= 4'h0;
    end else begin
      o_counter_clk <= clean; // R12
    end
  end
endmodule : tid_top
`default_nettype wire

// ### include/tid_pkg.sv
// tid_pkg: shared constants for the tachometer input conditioning block
package tid_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_A_OFS = 8'h00;
  localparam logic [7:0] CTRL_B_OFS = 8'h04;
  localparam logic [7:0] CTRL_C_OFS = 8'h08;
  localparam logic [7:0] CTRL_D_OFS = 8'h0C;
  localparam logic [7:0] SCAN_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;

  // ----------------------------------------------------------------
  // channel control, scan and status fields
  // ----------------------------------------------------------------
  localparam int CPL_BIT = 0;
  localparam int INV_BIT = 1;
  localparam int MODE_LSB = 2;
  localparam int IVL_LSB = 4;
  localparam int THR_LSB = 8;
  localparam int SCAN_SEL_LSB = 0;
  localparam int SCAN_GAIN_LSB = 8;
  localparam int STAT_IN_LSB = 4;

  // threshold code: step 100 mV from -12.5 V, 0 V in the middle
  localparam int THR_MIN_MV = -12500;
  localparam int THR_MAX_MV = 12500;
  localparam int THR_STEP_MV = 100;
  localparam logic [7:0] THR_MAX_CODE = 8'((THR_MAX_MV - THR_MIN_MV) / THR_STEP_MV);
  localparam logic [7:0] THR_RST = 8'((0 - THR_MIN_MV) / THR_STEP_MV);
  localparam logic [31:0] CTRL_RST = {16'h0000, THR_RST, 8'h01};
  localparam logic [31:0] SCAN_RST = 32'h00000000;

  typedef enum logic [1:0] {
    TID_MODE_AFTER = 2'b00,
    TID_MODE_BEFORE = 2'b01,
    TID_MODE_BYPASS = 2'b11,
    TID_MODE_BYPASS2 = 2'b10
  } tid_mode_t;

  // ----------------------------------------------------------------
  // debounce intervals, ns, and their cycle counts at 200 MHz
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int CNT_W = 23;
  localparam int IVL_NS [16] = '{0, 500, 1000, 2000, 5000, 10000, 20000, 50000,
    100000, 200000, 500000, 1000000, 2000000, 5000000, 10000000, 25500000};
  function automatic logic [16*CNT_W-1:0] tid_pack_cycles();
    logic [16*CNT_W-1:0] v;
    v = '0;
    for (int i = 0; i < 16; i++) begin
      v[i*CNT_W +: CNT_W] = CNT_W'(IVL_NS[i] / CLK_PERIOD_NS);
    end
    return v;
  endfunction : tid_pack_cycles
  localparam logic [16*CNT_W-1:0] IVL_CYCLES = tid_pack_cycles();

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : tid_pkg

// ### src/tid_sync.sv
// tid_sync: two-stage synchroniser for asynchronous levels
`timescale 1ns/100ps
`default_nettype none
module tid_sync #(
  parameter int WIDTH = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule : tid_sync
`default_nettype wire

// ### src/tid_debounce.sv
// tid_debounce: one channel of settle-then-pass / pass-then-hold debounce
`timescale 1ns/100ps
`default_nettype none
module tid_debounce #(
  parameter int CNT_W = 23
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_level,
  input wire logic [1:0] i_mode,
  input wire logic [CNT_W-1:0] i_limit,
  output logic o_level
);
  logic prev;
  logic [CNT_W-1:0] held;
  logic stable;
  logic changed;

  assign changed = (i_level != prev);
  assign stable = (held >= i_limit);

  // count cycles since the input last changed, saturating at the limit
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      prev <= 1'b0;
      held <= '0;
    end else begin
      prev <= i_level;
      if (changed) begin
        held <= CNT_W'(1); // R13
      end else if (!stable) begin
        held <= held + CNT_W'(1);
      end
    end
  end

  // output decision per mode
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_level <= 1'b0;
    end else begin
      case (i_mode)
        tid_pkg::TID_MODE_AFTER: begin
          if (i_limit == '0) begin
            o_level <= i_level;
          end else if (!changed && stable && i_level != o_level) begin
            o_level <= i_level; // R8
          end
        end
        tid_pkg::TID_MODE_BEFORE: begin
          if (i_limit == '0) begin
            o_level <= i_level;
          end else if (changed && stable) begin
            o_level <= i_level; // R9
          end else if (!changed && stable && i_level != o_level) begin
            o_level <= i_level; // R10
          end
        end
        default: begin
          o_level <= i_level; // R5
        end
      endcase
    end
  end
endmodule : tid_debounce
`default_nettype wire

// ### tb/tid_sensor_model.sv
// tid_sensor_model: behavioural tachometer sensor driving the four comparator pins
`timescale 1ns/100ps
`default_nettype none
module tid_sensor_model (
  input wire logic [3:0] i_level,
  output logic [3:0] o_pin
);
  // push-pull pins follow the asked level with a skew unrelated to the clock
  assign #1.3 o_pin = i_level;
endmodule : tid_sensor_model
`default_nettype wire

// ### tb/tid_top_sva.sv
// tid_top_sva: port-level assertions for the tachometer conditioning top
`timescale 1ns/100ps
`default_nettype none
module tid_top_sva #(
  parameter logic [16*tid_pkg::CNT_W-1:0] P_IVL_CYCLES = tid_pkg::IVL_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic [1:0] o_s_axi_bresp,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic [1:0] o_s_axi_rresp,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic i_speed_pulse_input_a,
  input wire logic i_speed_pulse_input_b,
  input wire logic i_speed_pulse_input_c,
  input wire logic i_speed_pulse_input_d,
  input wire logic [3:0] o_coupling_ac,
  input wire logic [7:0] o_threshold_b,
  input wire logic [3:0] o_counter_clk
);
  // longest interval plus pipeline margin
  localparam int QUIET = int'(P_IVL_CYCLES[15*tid_pkg::CNT_W +: tid_pkg::CNT_W]) + 16;
  int quiet;
  logic [3:0] pin_q;
  wire logic [3:0] pins = {i_speed_pulse_input_d, i_speed_pulse_input_c,
    i_speed_pulse_input_b, i_speed_pulse_input_a};

  // cycles since any pin moved or software wrote
  always_ff @(posedge i_sys_clk) begin
    pin_q <= pins;
    if (!i_rst_n || pins != pin_q || (i_s_axi_awvalid && o_s_axi_awready)) begin
      quiet <= 0;
    end else if (quiet < QUIET) begin
      quiet <= quiet + 1;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_wr_taken;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  endsequence
  sequence s_rd_taken;
    i_s_axi_arvalid && o_s_axi_arready;
  endsequence

  AST_WR_ANSWER: assert property (s_wr_taken |-> ##[1:2] o_s_axi_bvalid)
    else $error("write not answered");
  AST_B_HOLD: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
    o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("write answer dropped");
  AST_RD_OK: assert property (s_rd_taken ##0 (i_s_axi_araddr <= 8'h14) |=>
    o_s_axi_rvalid && o_s_axi_rresp == 2'b00) else $error("mapped read bad");
  AST_RD_BAD: assert property (s_rd_taken ##0 (i_s_axi_araddr > 8'h14) |=>
    o_s_axi_rvalid && o_s_axi_rresp == 2'b10 && o_s_axi_rdata == 32'h0)
    else $error("unmapped read bad");
  AST_R_HOLD: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
    o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read answer dropped");
  AST_AW_PULSE: assert property (o_s_axi_awready |=> !o_s_axi_awready)
    else $error("awready held");
  AST_THR_RANGE: assert property (o_threshold_b <= 8'hFA)
    else $error("threshold code past top");
  AST_RESET_VAL: assert property ($rose(i_rst_n) |-> o_coupling_ac == 4'hF &&
    o_threshold_b == 8'h7D && o_counter_clk == 4'h0) else $error("reset values bad");
  AST_CTR_QUIET: assert property (quiet >= QUIET |-> $stable(o_counter_clk))
    else $error("pulse output moved without cause");
endmodule : tid_top_sva

bind tid_top tid_top_sva #(.P_IVL_CYCLES(P_IVL_CYCLES)) u_sva (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
  .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
  .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
  .o_s_axi_bresp(o_s_axi_bresp), .o_s_axi_bvalid(o_s_axi_bvalid),
  .i_s_axi_bready(i_s_axi_bready), .i_s_axi_araddr(i_s_axi_araddr),
  .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
  .o_s_axi_rdata(o_s_axi_rdata), .o_s_axi_rresp(o_s_axi_rresp),
  .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready),
  .i_speed_pulse_input_a(i_speed_pulse_input_a), .i_speed_pulse_input_b(i_speed_pulse_input_b),
  .i_speed_pulse_input_c(i_speed_pulse_input_c), .i_speed_pulse_input_d(i_speed_pulse_input_d),
  .o_coupling_ac(o_coupling_ac), .o_threshold_b(o_threshold_b),
  .o_counter_clk(o_counter_clk));
`default_nettype wire

// ### tb/testbench.sv
// testbench: self-checking bench for the tachometer conditioning top
`timescale 1ns/100ps
`default_nettype none
module testbench;
  typedef struct {int ch; logic [7:0] ctl; int w; int n; int e;} tid_row_t;
  logic sys_clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, thr_a, thr_b, thr_c, thr_d;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, lvl, pin, cpl, sgain, cclk, cclk_q;
  logic [1:0] bresp, rresp, ssel;
  int errors, comparisons, edges[4];

  // short intervals: code i lasts 4*i cycles
  function automatic logic [16*tid_pkg::CNT_W-1:0] ivl_tab();
    logic [16*tid_pkg::CNT_W-1:0] v;
    v = '0;
    for (int i = 0; i < 16; i++) begin
      v[i*tid_pkg::CNT_W +: tid_pkg::CNT_W] = tid_pkg::CNT_W'(4 * i);
    end
    return v;
  endfunction : ivl_tab
  localparam logic [16*tid_pkg::CNT_W-1:0] IVL = ivl_tab();

  // rows: channel, control byte, pulse width, pulse count, rising edges expected
  tid_row_t rows[13] = '{
    '{0, 8'h40, 6, 1, 0}, '{2, 8'h40, 40, 1, 1}, '{3, 8'h40, 2, 3, 0},
    '{0, 8'h44, 6, 1, 1}, '{2, 8'h44, 2, 3, 1}, '{3, 8'h44, 40, 1, 1},
    '{0, 8'h4C, 2, 3, 3}, '{2, 8'h48, 6, 1, 1}, '{3, 8'h00, 2, 1, 1},
    '{0, 8'h42, 40, 1, 1}, '{2, 8'h4E, 2, 3, 3}, '{3, 8'hF0, 40, 1, 0},
    '{0, 8'hF0, 90, 1, 1}};

  tid_sensor_model u_sensor (.i_level(lvl), .o_pin(pin));
  tid_top #(.P_IVL_CYCLES(IVL)) dut (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .i_speed_pulse_input_a(pin[0]), .i_speed_pulse_input_b(pin[1]),
    .i_speed_pulse_input_c(pin[2]), .i_speed_pulse_input_d(pin[3]),
    .o_coupling_ac(cpl), .o_threshold_a(thr_a), .o_threshold_b(thr_b),
    .o_threshold_c(thr_c), .o_threshold_d(thr_d), .o_scan_sel(ssel),
    .o_scan_gain(sgain), .o_counter_clk(cclk));

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // counts rising edges of each cleaned pulse, away from the launching edge
  always @(negedge sys_clk) begin
    for (int c = 0; c < 4; c++) begin
      if (cclk[c] && !cclk_q[c]) edges[c]++;
    end
    cclk_q <= cclk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    int t;
    logic aw, w, b;
    logic [1:0] br;
    t = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge sys_clk);
      {aw, w, b, br} = {awready, wready, bvalid, bresp};
      @(posedge sys_clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      t++;
    end while (!b && t < 100);
    bready <= 1'b0;
    cmp({b, br}, {1'b1, r});
    @(posedge sys_clk); // one edge between requests, lets registered outputs settle
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int t;
    logic ar, v;
    logic [1:0] rp;
    logic [31:0] dat;
    t = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge sys_clk);
      {ar, v, rp, dat} = {arready, rvalid, rresp, rdata};
      @(posedge sys_clk);
      if (ar) arvalid <= 1'b0;
      t++;
    end while (!v && t < 100);
    rready <= 1'b0;
    cmp({v, rp}, {1'b1, r});
    cmp(dat, d);
  endtask : rd

  task automatic close_out();
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // cuts a hang short
  initial begin
    #200000;
    errors++;
    close_out();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    tid_row_t r;
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, lvl} = '0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    foreach (rows[i]) begin
      r = rows[i];
      wr(8'(r.ch * 4), {16'h0, 8'h7D, r.ctl}, 4'hF, tid_pkg::RESP_OKAY);
      repeat (100) @(posedge sys_clk);
      edges = '{0, 0, 0, 0};
      for (int k = 0; k < r.n; k++) begin
        lvl[r.ch] <= 1'b1;
        repeat (r.w) @(posedge sys_clk);
        lvl[r.ch] <= 1'b0;
        repeat (r.w) @(posedge sys_clk);
      end
      repeat (100) @(posedge sys_clk);
      for (int c = 0; c < 4; c++) begin
        cmp(edges[c], (c == r.ch) ? r.e : 0);
      end
    end
    rd(8'h18, 32'h0, tid_pkg::RESP_SLVERR);
    wr(8'h18, 32'hFFFFFFFF, 4'hF, tid_pkg::RESP_SLVERR);
    wr(tid_pkg::STATUS_OFS, 32'h0, 4'hF, tid_pkg::RESP_SLVERR);
    wr(tid_pkg::CTRL_B_OFS, 32'hFFFFFF00, 4'h2, tid_pkg::RESP_OKAY);
    rd(tid_pkg::CTRL_B_OFS, 32'h0000FF01, tid_pkg::RESP_OKAY);
    cmp(thr_b, 8'hFA);
    cmp({thr_a, thr_c, thr_d}, {3{8'h7D}});
    cmp(cpl, 4'h2);
    wr(tid_pkg::SCAN_OFS, 32'h00000A03, 4'hF, tid_pkg::RESP_OKAY);
    cmp({ssel, sgain}, {2'd3, 4'hA});
    rd(tid_pkg::SCAN_OFS, 32'h00000A03, tid_pkg::RESP_OKAY);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    cmp({cpl, thr_b, cclk}, {4'hF, 8'h7D, 4'h0});
    rd(tid_pkg::CTRL_A_OFS, 32'h00007D01, tid_pkg::RESP_OKAY);
    lvl <= 4'h5;
    repeat (20) @(posedge sys_clk);
    rd(tid_pkg::STATUS_OFS, 32'h00000055, tid_pkg::RESP_OKAY);
    close_out();
  end
endmodule : testbench
`default_nettype wire
